// ---- design/mtp_defines.vh ----
// register map, field layout and reset values of the motor trigger program block
`ifndef MTP_DEFINES_VH
`define MTP_DEFINES_VH
// byte offsets on the register bus
`define MTP_OFFSET_PROG_FOUR 12'h000
`define MTP_OFFSET_PROG_FIVE 12'h004
`define MTP_OFFSET_SELECT 12'h008
`define MTP_OFFSET_STATUS 12'h00c
// reset values
`define MTP_RESET_PROG 32'h00000000
`define MTP_RESET_SELECT 32'h00000000
// slot descriptor layout, relative to slot base bit
`define MTP_SLOT_WIDTH 8
`define MTP_SLOT_ENABLE_BIT 7
`define MTP_SLOT_PHASE_HI 6
`define MTP_SLOT_PHASE_LO 5
`define MTP_SLOT_INPUT_HI 4
`define MTP_SLOT_INPUT_LO 0
// phase tag encodings
`define MTP_PHASE_NONE 2'h0
`define MTP_PHASE_U 2'h1
`define MTP_PHASE_V 2'h2
`define MTP_PHASE_W 2'h3
// select register: bit 0 picks program five
`define MTP_SELECT_PROG_BIT 0
`endif

// ---- design/mtp_slot_decode.v ----
// one slot descriptor split into enable, phase tag and input select
`timescale 1ns/1ps
`include "mtp_defines.vh"
module mtp_slot_decode (
  input wire [7:0] descriptor,
  output wire slotEnable,
  output wire [1:0] phaseTag,
  output wire [4:0] inputSelect
);
  // top bit enables the slot
  assign slotEnable = descriptor[`MTP_SLOT_ENABLE_BIT];
  // two-bit phase tag for the vector engine
  assign phaseTag =
    descriptor[`MTP_SLOT_PHASE_HI:`MTP_SLOT_PHASE_LO];
  // analog input pin chooser
  assign inputSelect =
    descriptor[`MTP_SLOT_INPUT_HI:`MTP_SLOT_INPUT_LO];
endmodule // mtp_slot_decode

// ---- design/mtp_prog_reg.v ----
// one 32-bit trigger program register with word write
`timescale 1ns/1ps
`include "mtp_defines.vh"
module mtp_prog_reg (
  input wire sys_clk,
  input wire reset,
  input wire writeStrobe,
  input wire [31:0] writeData,
  output wire [31:0] progValue
);
  reg [31:0] prog_reg; // held program word

  // every bit clears on reset, software owns all bits after
  always @(posedge sys_clk) begin
    if (reset) begin
      prog_reg <= `MTP_RESET_PROG;
    end else if (writeStrobe) begin
      prog_reg <= writeData;
    end
  end

  assign progValue = prog_reg;
endmodule // mtp_prog_reg

// ---- design/mtp_trigger_regs.v ----
// motor trigger program registers with apb slave and slot dispatch
// Summary of operation
// - two program words, four byte-wide slots each
// - slot top bit enables its result
// - two-bit phase tag: none, U, V, W
// - five-bit analog input selector per slot
// - all fields read/write, clear on reset
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "mtp_defines.vh"
module mtp_trigger_regs (
  input wire sys_clk,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // trigger from the motor pwm unit, same clock
  input wire motorTrigger,
  // conversion request toward the converter, one slot per pulse
  output reg convStart,
  output reg [1:0] convSlot,
  output reg [1:0] convPhase,
  output reg [4:0] convInput,
  // converter reports completion of the current request
  input wire convDone,
  output reg seqBusy
);
  localparam IDLE = 2'h0; // waiting for a trigger
  localparam ISSUE = 2'h1; // pick next enabled slot
  localparam WAIT = 2'h2; // conversion in flight
  localparam LOAD = 2'h3; // snapshot settled, load enables

  wire [31:0] progFour; // program four word
  wire [31:0] progFive; // program five word
  wire writeFour; // program four write strobe
  wire writeFive; // program five write strobe
  wire accessPhase; // apb access cycle
  wire [31:0] activeProg; // program in use
  wire [3:0] slotEnable; // decoded enables
  wire [7:0] phaseFlat; // decoded phase tags
  wire [19:0] inputFlat; // decoded input selectors
  reg select_reg; // 1 selects program five
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] pending_reg; // slots still to run
  reg [3:0] pending_next;
  reg [1:0] slot_reg; // slot in flight
  reg [1:0] slot_next;
  reg [3:0] pick; // lowest pending slot, one-hot
  reg [1:0] pickIndex;
  integer i;

  assign accessPhase = psel & penable;
  // single-cycle access, so writes land at the access edge
  assign writeFour = accessPhase & pwrite &
    (paddr == `MTP_OFFSET_PROG_FOUR);
  assign writeFive = accessPhase & pwrite &
    (paddr == `MTP_OFFSET_PROG_FIVE);

  // two program words
  mtp_prog_reg progFourInst (
    .sys_clk(sys_clk),
    .reset(reset),
    .writeStrobe(writeFour),
    .writeData(pwdata),
    .progValue(progFour)
  );
  mtp_prog_reg progFiveInst (
    .sys_clk(sys_clk),
    .reset(reset),
    .writeStrobe(writeFive),
    .writeData(pwdata),
    .progValue(progFive)
  );

  // latched at trigger so a rewrite mid-sequence is harmless
  reg [31:0] snap_reg;
  assign activeProg = snap_reg;

  // slots 3..0 live at bits 31-24 down to 7-0
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : slotGen
      mtp_slot_decode slotInst (
        .descriptor(activeProg[g*8+7:g*8]),
        .slotEnable(slotEnable[g]),
        .phaseTag(phaseFlat[g*2+1:g*2]),
        .inputSelect(inputFlat[g*5+4:g*5])
      );
    end
  endgenerate

  // select register and apb answer, zero wait states
  always @(posedge sys_clk) begin
    if (reset) begin
      select_reg <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable; // ready in the access cycle
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        // decode in setup so data is registered for access
        case (paddr)
          `MTP_OFFSET_PROG_FOUR: begin
            prdata <= progFour;
          end
          `MTP_OFFSET_PROG_FIVE: begin
            prdata <= progFive;
          end
          `MTP_OFFSET_SELECT: begin
            prdata <= {31'h0, select_reg};
          end
          `MTP_OFFSET_STATUS: begin
            prdata <= {28'h0, convSlot, pending_reg == 4'h0,
              seqBusy};
          end
          default: begin
            // unmapped: zero data and an error answer
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (accessPhase & pwrite & (paddr == `MTP_OFFSET_SELECT)) begin
        select_reg <= pwdata[`MTP_SELECT_PROG_BIT];
      end
    end
  end

  // lowest pending slot first
  always @* begin
    pick = 4'h0;
    pickIndex = 2'h0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (pending_reg[i]) begin
        pick = 4'h1 << i;
        pickIndex = i[1:0];
      end
    end
  end

  // sequencer next state
  always @* begin
    state_next = state_reg;
    pending_next = pending_reg;
    slot_next = slot_reg;
    case (state_reg)
      IDLE: begin
        if (motorTrigger) begin
          state_next = LOAD;
        end
      end
      LOAD: begin
        // decoders now see the snapshot; only enabled slots queue up
        pending_next = slotEnable;
        state_next = ISSUE;
      end
      ISSUE: begin
        if (pending_reg == 4'h0) begin
          state_next = IDLE; // no slot left pending: all enabled slots done, or none enabled
        end else begin
          slot_next = pickIndex;
          pending_next = pending_reg & ~pick;
          state_next = WAIT;
        end
      end
      WAIT: begin
        if (convDone) begin
          state_next = ISSUE;
        end
      end
      default: begin
        state_next = IDLE;
      end
    endcase
  end

  // sequencer registers and conversion request outputs
  always @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= IDLE;
      pending_reg <= 4'h0;
      slot_reg <= 2'h0;
      snap_reg <= `MTP_RESET_PROG;
      convStart <= 1'b0;
      convSlot <= 2'h0;
      convPhase <= `MTP_PHASE_NONE;
      convInput <= 5'h00;
      seqBusy <= 1'b0;
    end else begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      pending_reg <= pending_next;
      convStart <= 1'b0;
      // snapshot at trigger so a rewrite mid-sequence is harmless
      if (state_reg == IDLE && motorTrigger) begin
        snap_reg <= select_reg ? progFive : progFour;
        seqBusy <= 1'b1;
      end
      // start the lowest pending slot
      if (state_reg == ISSUE && pending_reg != 4'h0) begin
        convStart <= slotEnable[pickIndex];
        convSlot <= pickIndex;
        convPhase <= phaseFlat[pickIndex*2 +: 2];
        convInput <= inputFlat[pickIndex*5 +: 5];
      end
      if (state_reg == ISSUE && pending_reg == 4'h0) begin
        seqBusy <= 1'b0;
      end
    end
  end
endmodule // mtp_trigger_regs

// ---- sim/mtp_trigger_regs_checker.sv ----
// port assertions for the motor trigger program registers
`timescale 1ns/1ps
module mtp_trigger_regs_checker (
  input logic sys_clk,
  input logic reset,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic motorTrigger,
  input logic convStart,
  input logic [1:0] convSlot,
  input logic [1:0] convPhase,
  input logic [4:0] convInput,
  input logic convDone,
  input logic seqBusy
);
  logic [31:0] fourReg; // shadow of program four
  logic [31:0] fiveReg; // shadow of program five
  logic selReg; // shadow of the program select bit
  wire acc = psel && penable;
  wire [31:0] selWord = selReg ? fiveReg : fourReg;
  // descriptor of the slot being started
  wire [7:0] desc = selWord[convSlot*8 +: 8];
  // shadows follow writes at the access edge, as the slave must
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fourReg <= 32'h00000000;
      fiveReg <= 32'h00000000;
      selReg <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == 12'h000) fourReg <= pwdata;
      if (paddr == 12'h004) fiveReg <= pwdata;
      if (paddr == 12'h008) selReg <= pwdata[0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_reset_clear: assert property (
    $past(reset) |-> prdata == 32'h00000000 && !seqBusy && !convStart)
    else $error("outputs not clear after reset");
  chk_read_four: assert property (
    acc && !pwrite && paddr == 12'h000 |-> prdata == fourReg)
    else $error("program four read back wrong");
  chk_read_five: assert property (
    acc && !pwrite && paddr == 12'h004 |-> prdata == fiveReg)
    else $error("program five read back wrong");
  chk_slot_enable: assert property (
    convStart |-> desc[7])
    else $error("disabled slot started a conversion");
  chk_slot_phase: assert property (
    convStart |-> convPhase == desc[6:5])
    else $error("phase tag differs from slot");
  chk_slot_input: assert property (
    convStart |-> convInput == desc[4:0])
    else $error("input select differs from slot");
  chk_zero_wait: assert property (
    psel && !penable |=> pready)
    else $error("no ready in access cycle");
  chk_bad_addr: assert property (
    acc && paddr > 12'h00c |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
endmodule // mtp_trigger_regs_checker
bind mtp_trigger_regs mtp_trigger_regs_checker i_chk (
  .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .motorTrigger(motorTrigger),
  .convStart(convStart), .convSlot(convSlot), .convPhase(convPhase),
  .convInput(convInput), .convDone(convDone), .seqBusy(seqBusy));

// ---- sim/mtp_trigger_regs_tb_top.sv ----
// self-checking bench for the motor trigger program registers
`timescale 1ns/1ps
module mtp_trigger_regs_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic motorTrigger = 1'b0, convDone = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd, word;
  wire [31:0] prdata;
  wire pready, pslverr, convStart, seqBusy;
  wire [1:0] convSlot, convPhase;
  wire [4:0] convInput;
  int numErrors = 0, checksDone = 0, cycles = 0;
  logic [31:0] pats [4] = '{32'ha5c33c5a, 32'h5a3cc3a5, 32'hffffffff,
    32'h80808080};
  always #5 sys_clk = ~sys_clk;
  mtp_trigger_regs i_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motorTrigger(motorTrigger), .convStart(convStart),
    .convSlot(convSlot), .convPhase(convPhase), .convInput(convInput),
    .convDone(convDone), .seqBusy(seqBusy));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // fire the trigger and look for one start within a bounded wait
  task automatic trig(input logic [8:0] exp, input logic want);
    logic got;
    got = 1'b0;
    @(posedge sys_clk);
    motorTrigger <= 1'b1;
    @(posedge sys_clk);
    motorTrigger <= 1'b0;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge sys_clk);
      got = (convStart === 1'b1);
      if (got) check({convSlot, convPhase, convInput}, exp);
      if (got) check(seqBusy, 1'b1);
    end
    check(got, want);
    convDone <= got;
    @(posedge sys_clk);
    convDone <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check(seqBusy, 1'b0);
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog far above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      giveVerdict();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h00000000);
    check(err, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h00000000);
    foreach (pats[i]) begin
      apb(1'b1, 12'h000, pats[i]);
      apb(1'b1, 12'h004, ~pats[i]);
      apb(1'b0, 12'h000, 32'h0);
      check(rd, pats[i]);
      apb(1'b0, 12'h004, 32'h0);
      check(rd, ~pats[i]);
    end
    $display("test field read back done");
    apb(1'b1, 12'h010, 32'hdeadbeef);
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h00000000);
    check(err, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, pats[3]);
    $display("test unmapped address done");
    // one enabled slot per program, every phase code once
    for (int p = 0; p < 4; p++) begin
      word = {24'h0, 1'b1, 2'(p), 5'(p + 3)} << (8 * p);
      apb(1'b1, p[0] ? 12'h004 : 12'h000, word);
      apb(1'b1, 12'h008, 32'(p[0]));
      trig({2'(p), 2'(p), 5'(p + 3)}, 1'b1);
    end
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h00000001);
    $display("test slot dispatch done");
    apb(1'b1, 12'h000, 32'h7f7f7f7f);
    apb(1'b1, 12'h008, 32'h0);
    trig(9'h000, 1'b0);
    $display("test disabled slots done");
    giveVerdict();
  end
endmodule // mtp_trigger_regs_tb_top
